// ===== verilog/fab_regs.sv
/*
 * Bank select and protection configuration registers of a serial flash,
 * with the command decoder of the serial link (mode 0) and the fault flags.
 * Assumes link pins are asynchronous and sck is well below clk_in / 4;
 * reset pulses, fault events and the address request come from logic on clk_in.
 */
// Functional notes
// (R1) One-time bits only move from one to zero; reverse writes ignored silently.
// (R2) Read-only and freeze-held bits never change on writes; no error raised.
// (R3) Fault flags stay set until the clear-fault command.
// (R4) Hardware or software reset also clears the fault flags.
// (R5) Set fault flags never block command execution.
// (R6) Bank register is 8 bits, resets to zero; bits 6..2 read-only.
// (R7) Two bank bits select one 128Mb segment in 3-byte addressing.
// (R8) With width select 0, bank bits supply address bits above A23.
// (R9) With width select 1, bank bits ignored; host supplies four address bytes.
// (R10) Width select starts at zero, so 3-byte addressing after reset.
// (R11) Decode 16h/C8h read, 17h/C5h volatile write, 18h nonvolatile write.
// (R12) B7h enters and 29h exits 4-byte addressing.
// (R13) Protection register is 16 bits; 2Bh reads, 2Fh programs; reserved read-only.
// (R14) Bit 15 places parameter sectors high at 0, low at 1; default all ones.
// (R15) Bit 1 at zero fixes persistent protection mode.
// (R16) Bit 2 at zero fixes password protection mode.
// (R17) Unprogrammed locks give persistent mode with all sectors unprotected.
// (R18) Locks 11 none, 10 persistent fixed, 01 password fixed.
// (R19) Programming a lock bit zero fixes the mode permanently; here rst_in reloads PCFG_RESET, so the locks return to 11.
// (R20) Programming both locks to 00 aborts and sets the program fault.
// (R21) Further lock programming after mode selection is rejected with program fault.
// (R22) Protection register programming shows write-in-progress for a page-program time.
`timescale 1ns/10ps
module fab_regs
   import fab_pkg::*;
#(
   parameter int PROG_CNT = PROG_CYCLES
) (
   // Clock and reset
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   input  wire logic        hw_reset_in,
   input  wire logic        sw_reset_in,
   // Serial link pins
   input  wire logic        sck_in,
   input  wire logic        cs_n_in,
   input  wire logic        si_in,
   output logic             so_out,
   output logic             so_oe_out,
   // Array engine events and freeze lock
   input  wire logic        prot_fail_in,
   input  wire logic        prog_fail_in,
   input  wire logic        erase_fail_in,
   input  wire logic        freeze_in,
   // Address translation
   input  wire logic        addr_valid_in,
   input  wire logic [31:0] addr_in,
   output logic [25:0]      array_addr_out,
   // Configuration state
   output logic             wide_addr_sel_out,
   output logic [1:0]       bank_out,
   output logic             param_sector_place_out,
   output logic             persist_mode_lock_out,
   output logic             pwd_mode_lock_out,
   output logic             pwd_mode_active_out,
   output logic             write_in_progress_flag_out,
   output logic             prot_fault_flag_out,
   output logic             prog_fault_out,
   output logic             erase_fault_out
);

   typedef struct packed {
      logic        sck_m, sck_s, sck_p;
      logic        cs_m, cs_s, cs_p;
      logic        si_m, si_s;
      logic [7:0]  shreg;
      logic [4:0]  cnt;
      logic [7:0]  opcode;
      logic [15:0] data;
      logic [15:0] tx;
      logic        so, so_oe;
      logic [7:0]  bank, bank_nv;
      logic [15:0] pcfg;
      logic        pwd_mode;
      logic        prot_f, prog_f, erase_f;
      logic        busy;
      logic [15:0] busy_cnt;
      logic [25:0] array_addr;
   } fab_state_t;

   fab_state_t r;
   fab_state_t n;

   logic sck_rise, sck_fall, cs_rise, is_read, clr_now, prog_set, prot_set, pg_ok;
   logic [7:0] in_byte;

   assign sck_rise = r.sck_s & ~r.sck_p;
   assign sck_fall = ~r.sck_s & r.sck_p;
   assign cs_rise  = r.cs_s & ~r.cs_p;
   assign in_byte  = {r.shreg[6:0], r.si_s};
   assign is_read  = (r.cnt >= BITS_OPCODE) &&
                     (r.opcode == OP_BANK_RD_A || r.opcode == OP_BANK_RD_B ||
                      r.opcode == OP_PCFG_RD);

   always_comb begin
      n        = r;
      clr_now  = hw_reset_in | sw_reset_in;  // [R4]
      prog_set = prog_fail_in;
      prot_set = prot_fail_in;
      pg_ok    = 1'b0;
      n.sck_m  = sck_in;
      n.sck_s  = r.sck_m;
      n.sck_p  = r.sck_s;
      n.cs_m   = cs_n_in;
      n.cs_s   = r.cs_m;
      n.cs_p   = r.cs_s;
      n.si_m   = si_in;
      n.si_s   = r.si_m;
      if (!r.cs_s) begin
         if (sck_rise) begin
            n.shreg = in_byte;
            if (r.cnt != 5'h1F) begin
               n.cnt = r.cnt + 5'h01;
            end
            if (r.cnt == BITS_OPCODE - 5'h01) begin
               n.opcode = in_byte;
               if (in_byte == OP_PCFG_RD) begin
                  n.tx = {r.pcfg[7:0], r.pcfg[15:8]};  // [R13]
               end else begin
                  n.tx = {r.bank, r.bank};  // [R11]
               end
            end
            if (r.cnt == BITS_ONE_BYTE - 5'h01) begin
               n.data[7:0] = in_byte;
            end
            if (r.cnt == BITS_TWO_BYTE - 5'h01) begin
               n.data[15:8] = in_byte;
            end
         end
         if (sck_fall && is_read) begin
            n.so_oe = 1'b1;
            n.so    = r.tx[15];
            n.tx    = {r.tx[14:0], r.tx[15]};
         end
      end else begin
         n.cnt   = 5'h00;
         n.so_oe = 1'b0;
         n.so    = 1'b0;
      end
      // Commands act at the end of the frame, whatever the fault flags hold.
      if (cs_rise) begin  // [R5]
         case (r.opcode)
            OP_BANK_WV_A, OP_BANK_WV_B: begin
               if (r.cnt == BITS_ONE_BYTE && !r.busy) begin
                  n.bank = r.data[7:0] & BANK_WR_MASK;  // [R2] [R11]
               end
            end
            OP_BANK_WNV: begin
               if (r.cnt == BITS_ONE_BYTE && !r.busy) begin
                  n.bank_nv  = r.data[7:0] & BANK_WR_MASK;  // [R2] [R11]
                  n.busy     = 1'b1;
                  n.busy_cnt = PROG_CNT[15:0];
               end
            end
            OP_WIDE_EN: begin
               if (r.cnt == BITS_OPCODE && !r.busy) begin
                  n.bank[BANK_WIDE_BIT] = 1'b1;  // [R12]
               end
            end
            OP_WIDE_EX: begin
               if (r.cnt == BITS_OPCODE && !r.busy) begin
                  n.bank[BANK_WIDE_BIT] = 1'b0;  // [R12]
               end
            end
            OP_PCFG_PG: begin
               if (r.cnt == BITS_TWO_BYTE && !r.busy) begin
                  if (r.data[2:1] == LOCK_ILLEGAL ||
                      (r.pcfg[2:1] != LOCK_NONE && r.data[2:1] != LOCK_NONE)) begin
                     prog_set = 1'b1;  // [R20] [R21]
                     prot_set = 1'b1;
                  end else begin
                     pg_ok = 1'b1;
                     // One-time bits only clear; freeze holds the placement bit.
                     n.pcfg[2:1] = r.pcfg[2:1] & r.data[2:1];  // [R1] [R19]
                     n.pcfg[PCFG_PLACE_BIT] = r.pcfg[PCFG_PLACE_BIT] &
                                              (freeze_in | r.data[15]);  // [R1] [R2] [R14]
                     n.busy     = 1'b1;  // [R22]
                     n.busy_cnt = PROG_CNT[15:0];
                  end
               end
            end
            OP_CLR_FAULT: begin
               if (r.cnt == BITS_OPCODE) begin
                  clr_now = 1'b1;  // [R3]
               end
            end
            default: begin
            end
         endcase
      end
      if (r.busy) begin
         n.busy_cnt = r.busy_cnt - 16'h0001;
         n.busy     = (r.busy_cnt != 16'h0001);
      end
      // A fault raised in the cycle of a clear still lands.
      n.prot_f  = (r.prot_f & ~clr_now) | prot_set;  // [R3] [R4]
      n.prog_f  = (r.prog_f & ~clr_now) | prog_set;  // [R3] [R4]
      n.erase_f = (r.erase_f & ~clr_now) | erase_fail_in;  // [R3] [R4]
      if (hw_reset_in || sw_reset_in) begin
         n.bank = r.bank_nv;
      end
      n.pwd_mode = (n.pcfg[2:1] == LOCK_PWD);  // [R15] [R16] [R18]
      if (addr_valid_in) begin
         if (r.bank[BANK_WIDE_BIT]) begin
            n.array_addr = addr_in[25:0];  // [R9]
         end else begin
            n.array_addr = {r.bank[1:0], addr_in[23:0]};  // [R7] [R8]
         end
      end
      if (rst_in) begin
         n         = '0;
         n.sck_m   = 1'b0;
         n.cs_m    = 1'b1;
         n.cs_s    = 1'b1;
         n.cs_p    = 1'b1;
         n.bank    = BANK_RESET;  // [R6] [R10]
         n.bank_nv = BANK_RESET;
         n.pcfg    = PCFG_RESET;  // [R14] [R17]
      end
   end

   always_ff @(posedge clk_in) begin
      r <= n;
   end

   assign so_out                     = r.so;
   assign so_oe_out                  = r.so_oe;
   assign array_addr_out             = r.array_addr;
   assign wide_addr_sel_out          = r.bank[BANK_WIDE_BIT];
   assign bank_out                   = r.bank[1:0];
   assign param_sector_place_out     = r.pcfg[PCFG_PLACE_BIT];
   assign persist_mode_lock_out      = r.pcfg[PCFG_PST_BIT];
   assign pwd_mode_lock_out          = r.pcfg[PCFG_PWD_BIT];
   assign pwd_mode_active_out        = r.pwd_mode;
   assign write_in_progress_flag_out = r.busy;
   assign prot_fault_flag_out        = r.prot_f;
   assign prog_fault_out             = r.prog_f;
   assign erase_fault_out            = r.erase_f;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   AST_OTP_ONE_WAY: assert property (!$past(rst_in) |-> // [R1] [R19]
      ((r.pcfg & PCFG_OTP_MASK & ~$past(r.pcfg)) == 16'h0000))
      else $error("one-time bit returned to one");
   AST_RESERVED_FIXED: assert property ((r.bank[6:2] == 5'h00) && // [R2] [R13]
      (r.pcfg[14:3] == 12'hFFF) && r.pcfg[0])
      else $error("reserved bit changed");
   AST_FAULT_STICKY: assert property (r.prot_f && !clr_now |=> r.prot_f) // [R3]
      else $error("protection fault dropped without clear");
   AST_RESET_CLEARS: assert property (sw_reset_in && !prog_set |=> !r.prog_f) // [R4]
      else $error("software reset left program fault set");
   AST_NOT_BLOCKED: assert property (r.prog_f && cs_rise && r.opcode == OP_WIDE_EN && // [R5]
      r.cnt == BITS_OPCODE && !r.busy |=> wide_addr_sel_out)
      else $error("fault flag blocked a command");
   AST_RESET_VALUES: assert property (disable iff (1'b0) rst_in |=> // [R6] [R10] [R14]
      (r.bank == BANK_RESET) && (r.pcfg == PCFG_RESET))
      else $error("wrong reset value");
   AST_BANK_ADDR: assert property (addr_valid_in && !r.bank[BANK_WIDE_BIT] |=> // [R8]
      array_addr_out[25:24] == $past(r.bank[1:0]))
      else $error("bank bits not used above A23");
   AST_WIDE_ADDR: assert property (addr_valid_in && r.bank[BANK_WIDE_BIT] |=> // [R9]
      array_addr_out == $past(addr_in[25:0]))
      else $error("bank bits used in wide mode");
   AST_ILLEGAL_LOCK: assert property (cs_rise && r.opcode == OP_PCFG_PG && // [R20]
      r.cnt == BITS_TWO_BYTE && !r.busy && r.data[2:1] == LOCK_ILLEGAL |=>
      r.prog_f && r.prot_f && (r.pcfg == $past(r.pcfg)) ##1 !r.busy)
      else $error("illegal lock pattern not refused");
   AST_PG_BUSY: assert property (pg_ok |=> r.busy [*8]) // [R22]
      else $error("write in progress not shown");
   AST_MODE_DECODE: assert property (r.pwd_mode == (r.pcfg[2:1] == LOCK_PWD)) // [R18]
      else $error("protection mode decode wrong");

   COV_WIDE_ENTER: cover property (cs_rise && r.opcode == OP_WIDE_EN ##1 wide_addr_sel_out);
   COV_PCFG_PROG: cover property (pg_ok ##1 r.busy);
   COV_ILLEGAL: cover property ($rose(r.prog_f) && r.opcode == OP_PCFG_PG);
   COV_READ: cover property ($rose(so_oe_out));

endmodule // fab_regs

// ===== verilog/fab_pkg.sv
/*
 * Constants for the bank select and protection configuration registers of a
 * serial flash: opcodes, field positions, reset values and timing counts.
 * Assumes a 100 MHz system clock that oversamples the serial link.
 */
package fab_pkg;
   // Command opcodes.
   localparam logic [7:0] OP_BANK_RD_A  = 8'h16;
   localparam logic [7:0] OP_BANK_RD_B  = 8'hC8;
   localparam logic [7:0] OP_BANK_WV_A  = 8'h17;
   localparam logic [7:0] OP_BANK_WV_B  = 8'hC5;
   localparam logic [7:0] OP_BANK_WNV   = 8'h18;
   localparam logic [7:0] OP_WIDE_EN    = 8'hB7;
   localparam logic [7:0] OP_WIDE_EX    = 8'h29;
   localparam logic [7:0] OP_PCFG_RD    = 8'h2B;
   localparam logic [7:0] OP_PCFG_PG    = 8'h2F;
   localparam logic [7:0] OP_CLR_FAULT  = 8'h82;

   // Bank and width select register.
   localparam int         BANK_WIDE_BIT = 7;
   localparam logic [7:0] BANK_RESET    = 8'h00;
   localparam logic [7:0] BANK_WR_MASK  = 8'h83;

   // Protection configuration register.
   localparam int          PCFG_PLACE_BIT = 15;
   localparam int          PCFG_PWD_BIT   = 2;
   localparam int          PCFG_PST_BIT   = 1;
   localparam logic [15:0] PCFG_RESET     = 16'hFFFF;
   localparam logic [15:0] PCFG_OTP_MASK  = 16'h8006;
   localparam logic [1:0]  LOCK_NONE      = 2'h3;
   localparam logic [1:0]  LOCK_PWD       = 2'h1;
   localparam logic [1:0]  LOCK_ILLEGAL   = 2'h0;

   // Serial bit counts at which a command is complete.
   localparam logic [4:0] BITS_OPCODE   = 5'h08;
   localparam logic [4:0] BITS_ONE_BYTE = 5'h10;
   localparam logic [4:0] BITS_TWO_BYTE = 5'h18;

   // Programming time of a nonvolatile update.
   localparam int CLK_PERIOD_NS = 10;
   localparam int PROG_TIME_NS  = 2000;
   localparam int PROG_CYCLES   = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// ===== bench/fab_host.sv
/* Host serial controller model, link mode 0, MSB first.
   Assumes clk_in at 100 MHz; the link clock runs at 160 ns only in frames. */
`timescale 1ns/10ps
module fab_host (
   // Clock
   input  wire logic clk_in,
   // Serial link
   output logic      sck_out,
   output logic      cs_n_out,
   output logic      si_out,
   input  wire logic so_in
);
   initial begin
      sck_out = 1'b0;
      cs_n_out = 1'b1;
      si_out = 1'b0;
   end
   task automatic half;
      repeat (8) @(posedge clk_in);
      #1;
   endtask
   // Sends n bits of tx from bit 23 down; rx keeps the last 16 bits sampled.
   task automatic xfer(input logic [23:0] tx, input int n, output logic [15:0] rx);
      rx = 16'h0;
      cs_n_out = 1'b0;
      half;
      for (int i = 0; i < n; i++) begin
         si_out = tx[23-i];
         half;
         sck_out = 1'b1;
         rx = {rx[14:0], so_in};
         half;
         sck_out = 1'b0;
      end
      half;
      cs_n_out = 1'b1;
      // A released data line shows no useful level.
      si_out = ~si_out;
      half;
      half;
   endtask
endmodule // fab_host

// ===== bench/testbench.sv
/* Self-checking bench of the bank select and protection registers.
   Assumes fab_host drives the serial link; notes are checked by a watcher. */
`timescale 1ns/10ps
module testbench;
   import fab_pkg::*;
   localparam int PCNT = 400;
   logic        clk_in, rst_in, hw_rst, sw_rst, frz, av, look, sck, cs_n, si, so, write_in_progress_flag, soe;
   logic        e_pl, e_w;
   logic [2:0]  fail, e_f;
   logic [1:0]  e_lk, e_b;
   logic [9:0]  stat;
   logic [7:0]  d;
   logic [15:0] rx;
   logic [25:0] aout;
   logic [31:0] addr;
   logic [33:0] e_note;
   logic [33:0] q[$];
   int          error_cnt, cmp_count;

   fab_regs #(.PROG_CNT(PCNT)) dut (
      .clk_in(clk_in), .rst_in(rst_in), .hw_reset_in(hw_rst), .sw_reset_in(sw_rst),
      .sck_in(sck), .cs_n_in(cs_n), .si_in(si), .so_out(so), .so_oe_out(soe),
      .prot_fail_in(fail[2]), .prog_fail_in(fail[1]), .erase_fail_in(fail[0]),
      .freeze_in(frz), .addr_valid_in(av), .addr_in(addr), .array_addr_out(aout),
      .wide_addr_sel_out(stat[2]), .bank_out(stat[1:0]), .param_sector_place_out(stat[3]),
      .persist_mode_lock_out(stat[4]), .pwd_mode_lock_out(stat[5]),
      .pwd_mode_active_out(stat[6]), .write_in_progress_flag_out(write_in_progress_flag),
      .prot_fault_flag_out(stat[9]), .prog_fault_out(stat[8]), .erase_fault_out(stat[7]));
   // The data-out line is pulled high whenever the device does not drive it.
   fab_host host (.clk_in(clk_in), .sck_out(sck), .cs_n_out(cs_n), .si_out(si),
                  .so_in(soe ? so : 1'b1));

   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic close_out;
      $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic note(input logic [1:0] s, input logic [31:0] v);
      q.push_back({s, v});
      look = 1'b1;
      @(posedge clk_in);
      #1 look = 1'b0;
      @(posedge clk_in);
      #1;
   endtask
   task automatic chk_st;
      note(2'h0, {22'h0, e_f, e_lk == LOCK_PWD, e_lk, e_pl, e_w, e_b});
   endtask
   task automatic cmd(input logic [23:0] tx, input int n);
      host.xfer(tx, n, rx);
   endtask
   task automatic pg(input logic [15:0] v);
      cmd({OP_PCFG_PG, v[7:0], v[15:8]}, 24);
   endtask
   task automatic idle;
      for (int i = 0; i < 1000 && write_in_progress_flag !== 1'b0; i++) @(posedge clk_in);
      #1;
   endtask
   task automatic addr_chk;
      addr = $urandom;
      av = 1'b1;
      @(posedge clk_in);
      #1 av = 1'b0;
      note(2'h2, e_w ? {6'h0, addr[25:0]} : {6'h0, e_b, addr[23:0]});
   endtask
   task automatic do_reset;
      rst_in = 1'b1;
      repeat (4) @(posedge clk_in);
      #1 rst_in = 1'b0;
      repeat (4) @(posedge clk_in);
      #1;
   endtask

   // Watcher: each result is compared with the oldest note.
   always @(posedge clk_in) begin
      if (look === 1'b1) begin
         e_note = q.pop_front();
         case (e_note[33:32])
            2'h0: check({22'h0, stat}, e_note[31:0]);
            2'h1: check({16'h0, rx}, e_note[31:0]);
            2'h2: check({6'h0, aout}, e_note[31:0]);
            default: check({31'h0, write_in_progress_flag}, e_note[31:0]);
         endcase
      end
   end

   initial begin
      #300000;
      error_cnt++;
      close_out;
   end

   initial begin
      void'($urandom(32'h4A62));
      {hw_rst, sw_rst, frz, av, look} = 5'h0;
      fail = 3'h0;
      addr = 32'h0;
      error_cnt = 0;
      cmp_count = 0;
      {e_f, e_lk, e_pl, e_w, e_b} = {3'h0, LOCK_NONE, 1'b1, 1'b0, 2'h0};
      do_reset;
      chk_st;
      cmd({OP_PCFG_RD, 16'h0}, 24);
      note(2'h1, 32'hFFFF);
      for (int i = 0; i < 2; i++) begin
         d = 8'($urandom);
         cmd({i ? OP_BANK_WV_B : OP_BANK_WV_A, d, 8'h0}, 16);
         {e_w, e_b} = {d[7], d[1:0]};
         cmd({i ? OP_BANK_RD_B : OP_BANK_RD_A, 16'h0}, 24);
         note(2'h1, {16'h0, {2{d & BANK_WR_MASK}}});
         addr_chk;
      end
      cmd({OP_WIDE_EN, 16'h0}, 8);
      e_w = 1'b1;
      addr_chk;
      cmd({OP_WIDE_EX, 16'h0}, 8);
      e_w = 1'b0;
      addr_chk;
      cmd({OP_BANK_WV_A, 8'h83, 8'h0}, 15);
      chk_st;
      for (int j = 0; j < 3; j++) begin
         fail = 3'h7;
         @(posedge clk_in);
         #1 fail = 3'h0;
         e_f = 3'h7;
         cmd({OP_BANK_WV_A, 8'h01, 8'h0}, 16);
         {e_w, e_b} = 3'h1;
         chk_st;
         if (j == 0) begin
            cmd({OP_CLR_FAULT, 16'h0}, 8);
         end else begin
            {hw_rst, sw_rst} = (j == 1) ? 2'h2 : 2'h1;
            @(posedge clk_in);
            #1 {hw_rst, sw_rst} = 2'h0;
            e_b = 2'h0;
         end
         e_f = 3'h0;
         chk_st;
      end
      cmd({OP_BANK_WNV, 8'h02, 8'h0}, 16);
      note(2'h3, 32'h1);
      // A write while the nonvolatile update runs must be refused.
      cmd({OP_WIDE_EN, 16'h0}, 8);
      chk_st;
      idle;
      hw_rst = 1'b1;
      @(posedge clk_in);
      #1 hw_rst = 1'b0;
      e_b = 2'h2;
      chk_st;
      frz = 1'b1;
      pg(16'h7FFF);
      idle;
      chk_st;
      frz = 1'b0;
      pg(16'h7FFF);
      e_pl = 1'b0;
      note(2'h3, 32'h1);
      idle;
      chk_st;
      pg(16'hFFFF);
      idle;
      chk_st;
      cmd({OP_PCFG_RD, 16'h0}, 24);
      note(2'h1, 32'hFF7F);
      // The host breaks its side here: both lock bits programmed to zero.
      pg(16'hFFF9);
      e_f = 3'h6;
      note(2'h3, 32'h0);
      chk_st;
      cmd({OP_CLR_FAULT, 16'h0}, 8);
      e_f = 3'h0;
      pg(16'hFFFB);
      e_lk = LOCK_PWD;
      idle;
      chk_st;
      pg(16'hFFFD);
      e_f = 3'h6;
      idle;
      chk_st;
      do_reset;
      {e_f, e_lk, e_pl, e_b} = {3'h0, LOCK_NONE, 1'b1, 2'h0};
      pg(16'hFFFD);
      e_lk = 2'h2;
      idle;
      chk_st;
      close_out;
   end
endmodule // testbench
